// >>> hw/param_frame_pkg.sv
// Shared constants for the parameter command frame link
package param_frame_pkg;

  // Frame bytes
  localparam logic [7:0]  START_DELIM    = 8'h7E;
  localparam logic [7:0]  TYPE_SET_NOW   = 8'h08;
  localparam logic [7:0]  TYPE_QUEUE     = 8'h09;
  localparam logic [7:0]  TYPE_RESPONSE  = 8'h88;
  localparam logic [7:0]  CSUM_TARGET    = 8'hFF;
  localparam logic [7:0]  ID_NO_RESPONSE = 8'h00;
  localparam logic [7:0]  LEN_HI_ZERO    = 8'h00;

  // Byte positions within a frame
  localparam logic [15:0] OFS_LEN_HI     = 16'h0001;
  localparam logic [15:0] OFS_LEN_LO     = 16'h0002;
  localparam logic [15:0] OFS_TYPE       = 16'h0003;
  localparam logic [15:0] OFS_ID         = 16'h0004;
  localparam logic [15:0] OFS_CMD_HI     = 16'h0005;
  localparam logic [15:0] OFS_CMD_LO     = 16'h0006;
  localparam logic [15:0] OFS_REQ_VAL    = 16'h0007;
  localparam logic [15:0] OFS_STATUS     = 16'h0007;
  localparam logic [15:0] OFS_RSP_VAL    = 16'h0008;

  // Length field figures
  localparam logic [15:0] MIN_BODY_LEN   = 16'h0004;
  localparam logic [15:0] MAX_BODY_LEN   = 16'h0008;
  localparam logic [15:0] RSP_FIXED_LEN  = 16'h0005;
  localparam logic [2:0]  MAX_VAL_BYTES  = 3'h4;
  localparam logic [2:0]  TEMP_VAL_BYTES = 3'h2;

  // Response status codes
  localparam logic [7:0]  ST_OK          = 8'h00;
  localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
  localparam logic [7:0]  ST_BAD_PARAM   = 8'h03;

  // Command codes, two ASCII characters
  localparam logic [15:0] apply_pending_cmd    = 16'h4143;
  localparam logic [15:0] temperature_read_cmd = 16'h5450;
  localparam logic [15:0] node_label_cmd       = 16'h4E49;
  localparam logic [15:0] baud_rate_cmd        = 16'h4244;
  localparam logic [15:0] channel_cmd          = 16'h4348;
  localparam logic [15:0] network_id_cmd       = 16'h4944;

  // Parameter store
  localparam int                     NUM_SLOTS  = 4;
  localparam int                     SLOT_W     = 2;
  localparam logic [3:0][15:0]       SLOT_CODES = {network_id_cmd, channel_cmd,
                                                   baud_rate_cmd, node_label_cmd};
  localparam logic [31:0]            SLOT_RESET = 32'h0000_0000;

endpackage

// >>> hw/cmd_link_if.sv
// Byte stream link between host controller and parameter device
`timescale 1ns/1ns
interface cmd_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport host (
    output h2d_data,
    output h2d_valid,
    input  h2d_ready,
    input  d2h_data,
    input  d2h_valid,
    output d2h_ready
  );

  modport dev (
    input  h2d_data,
    input  h2d_valid,
    output h2d_ready,
    output d2h_data,
    output d2h_valid,
    input  d2h_ready
  );
endinterface

// >>> hw/param_frame_dev.sv
// Device end: parses parameter command frames and answers them
//
// Function
// - Frame starts with the start delimiter byte
// - Two length bytes, high first, count body
// - Type 08 with value writes effective now
// - Type 09 with value holds it pending
// - Pending applied on type 08 or apply
// - Identifier zero suppresses the response frame
// - Two ASCII characters select the command
// - No value bytes means a read query
// - Query answers type 88 with effective value
// - Response carries the request identifier byte
// - Checksum is FF minus body byte sum
// - Queued value bytes stored for later use
// - Bytes travel unescaped on the link
`timescale 1ns/1ns
module param_frame_dev
  import param_frame_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  cmd_link_if.dev                    link,
  input  wire logic [15:0]           temp_i,
  output logic [NUM_SLOTS-1:0][31:0] eff_value_o,
  output logic [NUM_SLOTS-1:0]       pending_o,
  output logic                       apply_o
);

  typedef enum logic [2:0] {
    S_HUNT,
    S_LEN_HI,
    S_LEN_LO,
    S_BODY,
    S_CSUM,
    S_EXEC,
    S_SEND
  } dev_state_t;

  dev_state_t                  state_r;
  logic [15:0]                 len_r;
  logic [15:0]                 pos_r;
  logic [7:0]                  sum_r;
  logic [7:0]                  type_r;
  logic [7:0]                  id_r;
  logic [15:0]                 cmd_r;
  logic [31:0]                 val_r;
  logic [7:0]                  status_r;
  logic [31:0]                 rsp_val_r;
  logic [2:0]                  rsp_nval_r;
  logic [15:0]                 tx_pos_r;
  logic [7:0]                  tx_byte_r;
  logic [7:0]                  tx_sum_r;
  logic [NUM_SLOTS-1:0][31:0]  pend_val_r;
  logic [7:0]                  rx_byte;
  logic                        rx_take;
  logic                        tx_take;
  logic                        csum_good;
  logic                        query;
  logic                        too_long;
  logic                        is_apply;
  logic                        is_temp;
  logic                        hit;
  logic [SLOT_W-1:0]           slot;
  logic                        apply_now;
  logic                        write_ok;
  logic [15:0]                 tx_pos_nxt;
  logic [15:0]                 tx_last;
  logic [7:0]                  tx_sum_nxt;
  logic [7:0]                  tx_byte_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Link handshakes

  // Bytes are taken as they come, with no unescaping
  assign rx_byte        = link.h2d_data;
  assign link.h2d_ready = (state_r != S_EXEC) && (state_r != S_SEND);
  assign rx_take        = link.h2d_valid && link.h2d_ready;
  assign link.d2h_valid = (state_r == S_SEND);
  assign link.d2h_data  = tx_byte_r;
  assign tx_take        = link.d2h_valid && link.d2h_ready;
  assign csum_good      = 8'(sum_r + rx_byte) == CSUM_TARGET;

  ////////////////////////////////////////////////////////////////////////////
  // Frame state machine

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= S_HUNT;
    end else begin
      unique case (state_r)
        S_HUNT: begin
          if (rx_take && rx_byte == START_DELIM) begin
            state_r <= S_LEN_HI;
          end
        end
        S_LEN_HI: begin
          if (rx_take) begin
            state_r <= S_LEN_LO;
          end
        end
        S_LEN_LO: begin
          if (rx_take) begin
            // Too short to hold type, identifier and command
            state_r <= ({len_r[15:8], rx_byte} < MIN_BODY_LEN) ? S_HUNT : S_BODY;
          end
        end
        S_BODY: begin
          if (rx_take && pos_r == 16'(len_r + OFS_LEN_LO)) begin
            state_r <= S_CSUM;
          end
        end
        S_CSUM: begin
          if (rx_take) begin
            if (csum_good && (type_r == TYPE_SET_NOW || type_r == TYPE_QUEUE)) begin
              state_r <= S_EXEC;
            end else begin
              state_r <= S_HUNT;
            end
          end
        end
        S_EXEC: begin
          state_r <= (id_r == ID_NO_RESPONSE) ? S_HUNT : S_SEND;
        end
        S_SEND: begin
          if (tx_take && tx_pos_r == tx_last) begin
            state_r <= S_HUNT;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field capture

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      len_r  <= 16'h0000;
      pos_r  <= 16'h0000;
      sum_r  <= 8'h00;
      type_r <= 8'h00;
      id_r   <= 8'h00;
      cmd_r  <= 16'h0000;
      val_r  <= 32'h0000_0000;
    end else if (rx_take) begin
      if (state_r == S_LEN_HI) begin
        len_r[15:8] <= rx_byte;
      end
      if (state_r == S_LEN_LO) begin
        len_r[7:0] <= rx_byte;
        pos_r      <= OFS_TYPE;
        sum_r      <= 8'h00;
        val_r      <= 32'h0000_0000;
      end
      if (state_r == S_BODY) begin
        sum_r <= 8'(sum_r + rx_byte);
        pos_r <= 16'(pos_r + 16'h0001);
        if (pos_r == OFS_TYPE) begin
          type_r <= rx_byte;
        end else if (pos_r == OFS_ID) begin
          id_r <= rx_byte;
        end else if (pos_r == OFS_CMD_HI) begin
          cmd_r[15:8] <= rx_byte;
        end else if (pos_r == OFS_CMD_LO) begin
          cmd_r[7:0] <= rx_byte;
        end else begin
          val_r <= {val_r[23:0], rx_byte};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  always_comb begin
    hit  = 1'b0;
    slot = '0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (cmd_r == SLOT_CODES[i]) begin
        hit  = 1'b1;
        slot = SLOT_W'(i);
      end
    end
  end

  assign query     = (len_r == MIN_BODY_LEN);
  assign too_long  = (len_r > MAX_BODY_LEN);
  assign is_apply  = (cmd_r == apply_pending_cmd);
  assign is_temp   = (cmd_r == temperature_read_cmd);
  assign apply_now = (state_r == S_EXEC) && (type_r == TYPE_SET_NOW || is_apply);
  assign write_ok  = (state_r == S_EXEC) && hit && !query && !too_long;

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    logic sel;
    assign sel = write_ok && (slot == SLOT_W'(g));
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        eff_value_o[g] <= SLOT_RESET;
        pend_val_r[g]  <= SLOT_RESET;
        pending_o[g]   <= 1'b0;
      end else begin
        if (sel && type_r == TYPE_SET_NOW) begin
          eff_value_o[g] <= val_r;
          pending_o[g]   <= 1'b0;
        end else if (apply_now && pending_o[g]) begin
          eff_value_o[g] <= pend_val_r[g];
          pending_o[g]   <= 1'b0;
        end
        if (sel && type_r == TYPE_QUEUE) begin
          pend_val_r[g] <= val_r;
          pending_o[g]  <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      apply_o <= 1'b0;
    end else begin
      apply_o <= apply_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response contents

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_r   <= ST_OK;
      rsp_nval_r <= 3'h0;
    end else if (state_r == S_EXEC) begin
      if (!(hit || is_apply || is_temp)) begin
        status_r <= ST_BAD_CMD;
      end else if (too_long || (is_temp && !query)) begin
        status_r <= ST_BAD_PARAM;
      end else begin
        status_r <= ST_OK;
      end
      if (query && hit) begin
        rsp_nval_r <= MAX_VAL_BYTES;
      end else if (query && is_temp) begin
        rsp_nval_r <= TEMP_VAL_BYTES;
      end else begin
        rsp_nval_r <= 3'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response serialiser

  assign tx_pos_nxt = 16'(tx_pos_r + 16'h0001);
  assign tx_last    = 16'(OFS_RSP_VAL + {13'h0000, rsp_nval_r});
  assign tx_sum_nxt = 8'(tx_sum_r + ((tx_pos_r >= OFS_TYPE) ? tx_byte_r : 8'h00));

  always_comb begin
    tx_byte_nxt = 8'(CSUM_TARGET - tx_sum_nxt);
    if (tx_pos_nxt == OFS_LEN_HI) begin
      tx_byte_nxt = LEN_HI_ZERO;
    end else if (tx_pos_nxt == OFS_LEN_LO) begin
      tx_byte_nxt = 8'(RSP_FIXED_LEN + {13'h0000, rsp_nval_r});
    end else if (tx_pos_nxt == OFS_TYPE) begin
      tx_byte_nxt = TYPE_RESPONSE;
    end else if (tx_pos_nxt == OFS_ID) begin
      tx_byte_nxt = id_r;
    end else if (tx_pos_nxt == OFS_CMD_HI) begin
      tx_byte_nxt = cmd_r[15:8];
    end else if (tx_pos_nxt == OFS_CMD_LO) begin
      tx_byte_nxt = cmd_r[7:0];
    end else if (tx_pos_nxt == OFS_STATUS) begin
      tx_byte_nxt = status_r;
    end else if (tx_pos_nxt < tx_last) begin
      tx_byte_nxt = rsp_val_r[31:24];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_pos_r  <= 16'h0000;
      tx_byte_r <= 8'h00;
      tx_sum_r  <= 8'h00;
      rsp_val_r <= 32'h0000_0000;
    end else if (state_r == S_EXEC) begin
      tx_pos_r  <= 16'h0000;
      tx_byte_r <= START_DELIM;
      tx_sum_r  <= 8'h00;
      // Value is left aligned and leaves most significant byte first
      rsp_val_r <= is_temp ? {temp_i, 16'h0000} : eff_value_o[slot];
    end else if (tx_take) begin
      tx_pos_r  <= tx_pos_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_sum_r  <= tx_sum_nxt;
      if (tx_pos_nxt >= OFS_RSP_VAL) begin
        rsp_val_r <= {rsp_val_r[23:0], 8'h00};
      end
    end
  end

endmodule

// >>> hw/param_frame_host.sv
// Host end: builds request frames and parses response frames
`timescale 1ns/1ns
module param_frame_host
  import param_frame_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  cmd_link_if.host         link,
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic        req_queue_i,
  input  wire logic [7:0]  req_id_i,
  input  wire logic [15:0] req_cmd_i,
  input  wire logic [2:0]  req_nval_i,
  input  wire logic [31:0] req_value_i,
  output logic             rsp_valid_o,
  output logic             rsp_ok_o,
  output logic [7:0]       rsp_id_o,
  output logic [15:0]      rsp_cmd_o,
  output logic [7:0]       rsp_status_o,
  output logic [2:0]       rsp_nval_o,
  output logic [31:0]      rsp_value_o
);

  typedef enum logic [2:0] {
    R_HUNT,
    R_LEN_HI,
    R_LEN_LO,
    R_BODY,
    R_CSUM
  } host_rx_state_t;

  logic           busy_r;
  logic [7:0]     type_r;
  logic [7:0]     id_r;
  logic [15:0]    cmd_r;
  logic [2:0]     nval_r;
  logic [31:0]    val_r;
  logic [15:0]    tx_pos_r;
  logic [7:0]     tx_byte_r;
  logic [7:0]     tx_sum_r;
  logic [2:0]     nval_c;
  logic [15:0]    tx_pos_nxt;
  logic [15:0]    tx_last;
  logic [7:0]     tx_sum_nxt;
  logic [7:0]     tx_byte_nxt;
  logic           tx_take;
  host_rx_state_t rx_state_r;
  logic [15:0]    rx_len_r;
  logic [15:0]    rx_pos_r;
  logic [7:0]     rx_sum_r;
  logic [7:0]     rx_type_r;
  logic [7:0]     rx_byte;
  logic           rx_take;

  ////////////////////////////////////////////////////////////////////////////
  // Request serialiser

  assign req_ready_o    = !busy_r;
  assign link.h2d_valid = busy_r;
  assign link.h2d_data  = tx_byte_r;
  assign tx_take        = busy_r && link.h2d_ready;
  assign nval_c         = (req_nval_i > MAX_VAL_BYTES) ? MAX_VAL_BYTES : req_nval_i;
  assign tx_pos_nxt     = 16'(tx_pos_r + 16'h0001);
  assign tx_last        = 16'(OFS_REQ_VAL + {13'h0000, nval_r});
  assign tx_sum_nxt     = 8'(tx_sum_r + ((tx_pos_r >= OFS_TYPE) ? tx_byte_r : 8'h00));

  always_comb begin
    tx_byte_nxt = 8'(CSUM_TARGET - tx_sum_nxt);
    if (tx_pos_nxt == OFS_LEN_HI) begin
      tx_byte_nxt = LEN_HI_ZERO;
    end else if (tx_pos_nxt == OFS_LEN_LO) begin
      tx_byte_nxt = 8'(MIN_BODY_LEN + {13'h0000, nval_r});
    end else if (tx_pos_nxt == OFS_TYPE) begin
      tx_byte_nxt = type_r;
    end else if (tx_pos_nxt == OFS_ID) begin
      tx_byte_nxt = id_r;
    end else if (tx_pos_nxt == OFS_CMD_HI) begin
      tx_byte_nxt = cmd_r[15:8];
    end else if (tx_pos_nxt == OFS_CMD_LO) begin
      tx_byte_nxt = cmd_r[7:0];
    end else if (tx_pos_nxt < tx_last) begin
      tx_byte_nxt = val_r[31:24];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r    <= 1'b0;
      type_r    <= 8'h00;
      id_r      <= 8'h00;
      cmd_r     <= 16'h0000;
      nval_r    <= 3'h0;
      val_r     <= 32'h0000_0000;
      tx_pos_r  <= 16'h0000;
      tx_byte_r <= 8'h00;
      tx_sum_r  <= 8'h00;
    end else if (!busy_r) begin
      if (req_valid_i) begin
        busy_r    <= 1'b1;
        type_r    <= req_queue_i ? TYPE_QUEUE : TYPE_SET_NOW;
        id_r      <= req_id_i;
        cmd_r     <= req_cmd_i;
        nval_r    <= nval_c;
        // Left align so the most significant value byte leaves first
        val_r     <= req_value_i << {3'(MAX_VAL_BYTES - nval_c), 3'h0};
        tx_pos_r  <= 16'h0000;
        tx_byte_r <= START_DELIM;
        tx_sum_r  <= 8'h00;
      end
    end else if (tx_take) begin
      tx_pos_r  <= tx_pos_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_sum_r  <= tx_sum_nxt;
      if (tx_pos_nxt >= OFS_REQ_VAL) begin
        val_r <= {val_r[23:0], 8'h00};
      end
      if (tx_pos_r == tx_last) begin
        busy_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Response parser

  assign link.d2h_ready = 1'b1;
  assign rx_byte        = link.d2h_data;
  assign rx_take        = link.d2h_valid;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_state_r   <= R_HUNT;
      rx_len_r     <= 16'h0000;
      rx_pos_r     <= 16'h0000;
      rx_sum_r     <= 8'h00;
      rx_type_r    <= 8'h00;
      rsp_valid_o  <= 1'b0;
      rsp_ok_o     <= 1'b0;
      rsp_id_o     <= 8'h00;
      rsp_cmd_o    <= 16'h0000;
      rsp_status_o <= 8'h00;
      rsp_nval_o   <= 3'h0;
      rsp_value_o  <= 32'h0000_0000;
    end else begin
      rsp_valid_o <= 1'b0;
      if (rx_take) begin
        unique case (rx_state_r)
          R_HUNT: begin
            if (rx_byte == START_DELIM) begin
              rx_state_r <= R_LEN_HI;
            end
          end
          R_LEN_HI: begin
            rx_len_r[15:8] <= rx_byte;
            rx_state_r     <= R_LEN_LO;
          end
          R_LEN_LO: begin
            rx_len_r[7:0] <= rx_byte;
            rx_pos_r      <= OFS_TYPE;
            rx_sum_r      <= 8'h00;
            rsp_value_o   <= 32'h0000_0000;
            rx_state_r    <= ({rx_len_r[15:8], rx_byte} < RSP_FIXED_LEN) ? R_HUNT : R_BODY;
          end
          R_BODY: begin
            rx_sum_r <= 8'(rx_sum_r + rx_byte);
            rx_pos_r <= 16'(rx_pos_r + 16'h0001);
            if (rx_pos_r == OFS_TYPE) begin
              rx_type_r <= rx_byte;
            end else if (rx_pos_r == OFS_ID) begin
              rsp_id_o <= rx_byte;
            end else if (rx_pos_r == OFS_CMD_HI) begin
              rsp_cmd_o[15:8] <= rx_byte;
            end else if (rx_pos_r == OFS_CMD_LO) begin
              rsp_cmd_o[7:0] <= rx_byte;
            end else if (rx_pos_r == OFS_STATUS) begin
              rsp_status_o <= rx_byte;
            end else begin
              rsp_value_o <= {rsp_value_o[23:0], rx_byte};
            end
            if (rx_pos_r == 16'(rx_len_r + OFS_LEN_LO)) begin
              rx_state_r <= R_CSUM;
            end
          end
          R_CSUM: begin
            rx_state_r  <= R_HUNT;
            rsp_valid_o <= (rx_type_r == TYPE_RESPONSE);
            rsp_ok_o    <= 8'(rx_sum_r + rx_byte) == CSUM_TARGET;
            rsp_nval_o  <= (16'(rx_len_r - RSP_FIXED_LEN) > 16'(MAX_VAL_BYTES)) ?
                           MAX_VAL_BYTES : 3'(rx_len_r - RSP_FIXED_LEN);
          end
        endcase
      end
    end
  end

endmodule

// >>> bench/param_frame_props.sv
// Assertions on both directions of the host-device byte link
`timescale 1ns/1ns
module param_frame_props
  import param_frame_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  logic [15:0] h_cnt_r, h_len_r, d_cnt_r, d_len_r;
  logic [7:0]  h_sum_r, d_sum_r, h_id_r;
  logic        h_take, d_take, h_last, d_last;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  assign h_take = h2d_valid && h2d_ready;
  assign d_take = d2h_valid && d2h_ready;
  assign h_last = (h_cnt_r >= OFS_TYPE) && (h_cnt_r == h_len_r + 16'h0003);
  assign d_last = (d_cnt_r >= OFS_TYPE) && (d_cnt_r == d_len_r + 16'h0003);

  ////////////////////////////////////////////////////////////////////////////////
  // Position trackers for each direction
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      h_cnt_r <= '0;
      h_len_r <= '0;
      h_sum_r <= '0;
      h_id_r  <= '0;
    end else if (h_take) begin
      if (h_cnt_r == 16'h0000) h_cnt_r <= (h2d_data == START_DELIM) ? 16'h0001 : 16'h0000;
      else h_cnt_r <= h_last ? 16'h0000 : h_cnt_r + 16'h0001;
      if (h_cnt_r == OFS_LEN_HI) h_len_r[15:8] <= h2d_data;
      if (h_cnt_r == OFS_LEN_LO) h_len_r[7:0] <= h2d_data;
      if (h_cnt_r == OFS_ID) h_id_r <= h2d_data;
      h_sum_r <= (h_cnt_r < OFS_TYPE) ? 8'h00 : h_sum_r + h2d_data;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      d_cnt_r <= '0;
      d_len_r <= '0;
      d_sum_r <= '0;
    end else if (d_take) begin
      d_cnt_r <= d_last ? 16'h0000 : d_cnt_r + 16'h0001;
      if (d_cnt_r == OFS_LEN_HI) d_len_r[15:8] <= d2h_data;
      if (d_cnt_r == OFS_LEN_LO) d_len_r[7:0] <= d2h_data;
      d_sum_r <= (d_cnt_r < OFS_TYPE) ? 8'h00 : d_sum_r + d2h_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_host_delim: assert property (h2d_valid && h_cnt_r == 16'h0000 |-> h2d_data == START_DELIM)
    else $error("request frame does not open with delimiter");
  a_host_csum: assert property (h2d_valid && h_last |-> h2d_data == CSUM_TARGET - h_sum_r)
    else $error("request checksum wrong");
  a_host_hold: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
    else $error("request byte changed before taken");
  a_rsp_delim: assert property (d2h_valid && d_cnt_r == 16'h0000 |-> d2h_data == START_DELIM)
    else $error("response does not open with delimiter");
  a_rsp_len_hi: assert property (d2h_valid && d_cnt_r == OFS_LEN_HI |-> d2h_data == LEN_HI_ZERO)
    else $error("response length high byte wrong");
  a_rsp_type: assert property (d2h_valid && d_cnt_r == OFS_TYPE |-> d2h_data == TYPE_RESPONSE)
    else $error("response type wrong");
  a_rsp_id_match: assert property (d2h_valid && d_cnt_r == OFS_ID |-> d2h_data == h_id_r)
    else $error("response identifier differs from request");
  a_rsp_csum: assert property (d2h_valid && d_last |-> d2h_data == CSUM_TARGET - d_sum_r)
    else $error("response checksum wrong");
  a_quiet_id_zero: assert property ($rose(d2h_valid) |-> h_id_r != ID_NO_RESPONSE)
    else $error("response sent for identifier zero");
  a_rsp_prompt: assert property (h_take && h_last && h_id_r != ID_NO_RESPONSE
      |-> ##[1:3] (d2h_valid && d_cnt_r == 16'h0000))
    else $error("no response after good request");

  c_slot_query: cover property (d_take && d_cnt_r == 16'h000C);
  c_four_bytes: cover property (h_take && h_cnt_r == 16'h000A);
  c_rsp_start: cover property ($rose(d2h_valid));
endmodule

// >>> bench/test_local_param_command_frames.sv
// Testbench joining host and device ends, plus a device fed directly
`timescale 1ns/1ns
module test_local_param_command_frames
  import param_frame_pkg::*;
;
  logic                        mclk_i, sys_rst_i, req_valid_i, req_queue_i, req_ready_o;
  logic                        rsp_valid_o, rsp_ok_o, apply_o;
  logic [7:0]                  req_id_i, rsp_id_o, rsp_status_o;
  logic [15:0]                 req_cmd_i, rsp_cmd_o, temp_i;
  logic [2:0]                  req_nval_i, rsp_nval_o;
  logic [31:0]                 req_value_i, rsp_value_o;
  logic [NUM_SLOTS-1:0][31:0]  eff_value_o, eff_f;
  logic [NUM_SLOTS-1:0]        pending_o;
  int                          mismatches = 0, num_checks = 0, n_rsp = 0, n_apply = 0, n_f = 0;

  cmd_link_if lk ();
  cmd_link_if lk_f ();
  param_frame_host param_frame_host_i (.mclk_i, .sys_rst_i, .link(lk), .req_valid_i,
    .req_ready_o, .req_queue_i, .req_id_i, .req_cmd_i, .req_nval_i, .req_value_i,
    .rsp_valid_o, .rsp_ok_o, .rsp_id_o, .rsp_cmd_o, .rsp_status_o, .rsp_nval_o, .rsp_value_o);
  param_frame_dev param_frame_dev_i (.mclk_i, .sys_rst_i, .link(lk), .temp_i, .eff_value_o,
    .pending_o, .apply_o);
  param_frame_dev param_frame_dev_i2 (.mclk_i, .sys_rst_i, .link(lk_f), .temp_i(16'h0000),
    .eff_value_o(eff_f), .pending_o(), .apply_o());
  param_frame_props param_frame_props_i (.mclk_i, .sys_rst_i, .h2d_data(lk.h2d_data),
    .h2d_valid(lk.h2d_valid), .h2d_ready(lk.h2d_ready), .d2h_data(lk.d2h_data),
    .d2h_valid(lk.d2h_valid), .d2h_ready(lk.d2h_ready));

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (rsp_valid_o === 1'b1) n_rsp <= n_rsp + 1;
    if (apply_o === 1'b1) n_apply <= n_apply + 1;
    if (lk_f.d2h_valid === 1'b1 && lk_f.d2h_ready === 1'b1) n_f <= n_f + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task req(input logic q, input logic [7:0] id, input logic [15:0] cmd, input logic [2:0] n,
           input logic [31:0] v);
    int k;
    k = n_rsp;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_queue_i <= q;
    req_id_i    <= id;
    req_cmd_i   <= cmd;
    req_nval_i  <= n;
    req_value_i <= v;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1);
    req_valid_i <= 1'b0;
    for (int i = 0; i < 60 && n_rsp == k; i++) @(posedge mclk_i);
    chk(n_rsp - k, (id == ID_NO_RESPONSE) ? 0 : 1);
    if (id != ID_NO_RESPONSE) chk(rsp_id_o, id);
  endtask

  task put_f(input logic [7:0] b);
    lk_f.h2d_data  <= b;
    lk_f.h2d_valid <= 1'b1;
    do @(posedge mclk_i); while (lk_f.h2d_ready !== 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_queue;
    req(1'b1, 8'h53, baud_rate_cmd, 3'h1, 32'h7);
    chk(rsp_status_o, ST_OK);
    chk(pending_o[1], 1'b1);
    chk(eff_value_o[1], 32'h0);
  endtask

  task t_query;
    req(1'b1, 8'h17, baud_rate_cmd, 3'h0, 32'h0);
    chk(rsp_nval_o, 3'h4);
    chk(rsp_value_o, 32'h0);
    chk(pending_o[1], 1'b1);
  endtask

  task t_apply;
    int a;
    a = n_apply;
    req(1'b1, ID_NO_RESPONSE, apply_pending_cmd, 3'h0, 32'h0);
    chk(eff_value_o[1], 32'h7);
    chk(pending_o, 4'h0);
    chk(n_apply - a, 1);
  endtask

  task t_set_now;
    req(1'b0, 8'hA1, node_label_cmd, 3'h4, 32'h1234_5678);
    chk(eff_value_o[0], 32'h1234_5678);
    chk(rsp_cmd_o, node_label_cmd);
    chk(rsp_ok_o, 1'b1);
    req(1'b0, 8'hA2, node_label_cmd, 3'h0, 32'h0);
    chk(rsp_value_o, 32'h1234_5678);
  endtask

  task t_imm_apply;
    req(1'b1, 8'h02, channel_cmd, 3'h1, 32'hB);
    chk(eff_value_o[2], 32'h0);
    req(1'b0, 8'h03, temperature_read_cmd, 3'h0, 32'h0);
    chk(eff_value_o[2], 32'hB);
    chk(rsp_nval_o, 3'h2);
    chk(rsp_value_o, {16'h0000, temp_i});
    req(1'b0, 8'h04, temperature_read_cmd, 3'h1, 32'h5);
    chk(rsp_status_o, ST_BAD_PARAM);
    req(1'b1, 8'h05, 16'h5A5A, 3'h0, 32'h0);
    chk(rsp_status_o, ST_BAD_CMD);
  endtask

  task t_fault;
    logic [7:0] fr [11];
    logic [7:0] cs;
    int         f0;
    fr = '{8'h7E, 8'h00, 8'h08, 8'h08, 8'h01, 8'h4E, 8'h49, 8'h11, 8'h22, 8'h33, 8'h44};
    cs = CSUM_TARGET;
    for (int i = 3; i < 11; i++) cs = cs - fr[i];
    f0 = n_f;
    @(posedge mclk_i);
    foreach (fr[i]) put_f(fr[i]);
    put_f(cs ^ 8'h01);
    lk_f.h2d_valid <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk(eff_f[0], 32'h0);
    chk(n_f - f0, 0);
    put_f(8'h55);
    foreach (fr[i]) put_f(fr[i]);
    put_f(cs);
    lk_f.h2d_valid <= 1'b0;
    repeat (30) @(posedge mclk_i);
    chk(eff_f[0], 32'h1122_3344);
    chk(n_f - f0, 9);
  endtask

  task give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_i = 1'b0;
    sys_rst_i = 1'b1;
    {req_valid_i, req_queue_i, req_id_i, req_cmd_i, req_nval_i, req_value_i} = '0;
    temp_i = 16'h0123;
    lk_f.h2d_data = 8'h00;
    lk_f.h2d_valid = 1'b0;
    lk_f.d2h_ready = 1'b1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_queue;
    t_query;
    t_apply;
    t_set_now;
    t_imm_apply;
    t_fault;
    give_verdict;
  end

  initial begin
    #20000;
    mismatches++;
    give_verdict;
  end
endmodule
